// file: hdl/twwd_ms_timer.v
`timescale 1ns/1ps
// one-cycle enable every tick_cyc clocks
module twwd_ms_timer #(
   parameter TICK_CYC = 100000
) (
   // clock and reset
   input  wire        ref_clk,
   input  wire        rst,
   // tick enable
   output reg         tick_r
);
   reg [31:0] cnt_r;

   always @(posedge ref_clk) begin
      if (rst) begin
         cnt_r  <= 32'h0000_0000;
         tick_r <= 1'b0;
      end else if (cnt_r >= TICK_CYC - 1) begin
         cnt_r  <= 32'h0000_0000;
         tick_r <= 1'b1;
      end else begin
         cnt_r  <= cnt_r + 32'h0000_0001;
         tick_r <= 1'b0;
      end
   end
endmodule // twwd_ms_timer

// file: hdl/twwd_top.v
// Summary of operation
// R1: in software development mode a miss restarts long open window, no reset
// R2: any trigger failure sets the watchdog fail flags
// R3: fail flags clear on good trigger or when watchdog is off; the code keeps them when fail-safe follows a watchdog failure
// R4: time-out mode accepts a trigger anywhere in the period, restarting it
// R5: time-out expiry pulls reset low, then restart or fail-safe
// R6: window mode: closed then open window; trigger valid only when open
// R7: closed window is 60 percent of the selected period
// R8: host triggers between 0.72 and 1.20 of the period; the code expires the period at 1.0, so a trigger after that fails
// R9: closed-window trigger or expiry gives reset, then restart or fail-safe
// R10: control word bits 23..8 carry even parity
// R11: bad parity discards the command and sets the command error flag
// R12: reserved bits written count in the parity check
// R13: stop disable only from normal mode with both keys set
// R14: a sequence error clears key b; sequence restarts
// R15: stop-mode trigger or return to normal re-enables, clears both keys
// R16: key a cleared when sequence restarts; refused while key b clear
// R17: with wake restart set, a bus wake in stop restarts the watchdog
// R18: wake restart bit changes only in normal mode, before the sequence; the code also takes it in normal mode once the keys are set
// R19: bus wake in stop raises interrupt and pulls can receive low; the code does so only with the watchdog off and wake restart set
// R20: after long open window host serves as configured
// R21: to disable again host returns to normal and repeats the sequence
// R22: period select gives 10,20,50,100,200,500,1000,10000 ms
// R23: valid control write is the trigger and restarts with new setting
// R24: init, restart or reset release starts the long open window
// R25: long open window length is a parameter; trigger ends it
`timescale 1ns/1ps
`include "twwd_defines.vh"
module twwd_top #(
   parameter LONG_MS  = 200,
   parameter TICK_CYC = (`TWWD_CLK_HZ / 1000000) * `TWWD_TICK_US,
   parameter FAIL_TO_FAILSAFE = 0
) (
   // clock and reset
   input  wire        ref_clk,
   input  wire        rst,
   // apb slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // system events
   input  wire        bus_wake,
   // pins
   output reg         reset_out_n,
   output reg         can_receive_out,
   output reg         wake_irq
);
   // reset hold follows the tick length so a short tick shortens it too
   localparam LOW_CYC = TICK_CYC * `TWWD_LOW_US / `TWWD_TICK_US;
   localparam [1:0] S_LONG = 2'h0;
   localparam [1:0] S_RUN  = 2'h1;
   localparam [1:0] S_OFF  = 2'h2;
   localparam [1:0] S_LOW  = 2'h3;

   reg         wake_s1_r;
   reg         wake_s2_r;
   reg         wake_d_r;
   reg  [2:0]  mode_r;
   reg         cfg_window_r;
   reg  [2:0]  per_r;
   reg         key_a_r;
   reg         key_b_r;
   reg         wake_en_r;
   reg  [1:0]  fail_r;
   reg         cmd_err_r;
   reg  [1:0]  st_r;
   reg  [13:0] ms_r;
   reg  [31:0] low_r;
   reg         fail_wd_r;
   wire        tick;

   // R22: eight period codes
   // nominal period of each select code
   function [13:0] per_ms;
      input [2:0] sel;
      begin
         case (sel)
            3'h0:    per_ms = 14'd10;
            3'h1:    per_ms = 14'd20;
            3'h2:    per_ms = 14'd50;
            3'h3:    per_ms = 14'd100;
            3'h4:    per_ms = 14'd200;
            3'h5:    per_ms = 14'd500;
            3'h6:    per_ms = 14'd1000;
            default: per_ms = 14'd10000;
         endcase
      end
   endfunction

   // R7: closed window 60 percent
   function [13:0] closed_ms;
      input [2:0] sel;
      reg   [31:0] p;
      begin
         p = {18'h0, per_ms(sel)} * `TWWD_CLOSED_PCT;
         p = p / `TWWD_PCT_DIV;
         closed_ms = p[13:0];
      end
   endfunction

   twwd_ms_timer #(.TICK_CYC(TICK_CYC)) twwd_ms_timer_inst (
      .ref_clk (ref_clk),
      .rst     (rst),
      .tick_r  (tick)
   );

   // wake pin comes from another domain
   always @(posedge ref_clk) begin
      if (rst) begin
         wake_s1_r <= 1'b0;
         wake_s2_r <= 1'b0;
         wake_d_r  <= 1'b0;
      end else begin
         wake_s1_r <= bus_wake;
         wake_s2_r <= wake_s1_r;
         wake_d_r  <= wake_s2_r;
      end
   end
   wire wake_rise = wake_s2_r & ~wake_d_r;

   wire acc    = psel & penable & pready;
   wire wr     = acc & pwrite;
   wire wr_ctl = wr & (paddr == `TWWD_CTRL_OFS);
   wire wr_hw  = wr & (paddr == `TWWD_HWCTRL_OFS);
   wire wr_md  = wr & (paddr == `TWWD_MODE_OFS);
   // R10: even parity over 23..8
   // R12: reserved bits included as written
   wire par_ok = ~(^pwdata[`TWWD_CK_BIT:`TWWD_PAR_LO]);
   wire in_normal = (mode_r == `TWWD_M_NORMAL) |
                    (mode_r == `TWWD_M_SWDEV);
   wire [2:0] new_mode = pwdata[`TWWD_MODE_HI:`TWWD_MODE_LO];
   // R23: valid control write is the trigger
   wire trig = wr_ctl & par_ok;
   wire in_closed = cfg_window_r & (ms_r < closed_ms(per_r));
   wire expired = (ms_r >= per_ms(per_r)) & tick;
   wire long_end = (ms_r >= LONG_MS) & tick;
   // R9: closed-window trigger is a failure
   wire bad_trig = trig & (st_r == S_RUN) & in_closed;
   // R5: expiry fails
   wire miss = (st_r == S_RUN) & expired & ~trig;

   always @(posedge ref_clk) begin
      if (rst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= psel & ~pready;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
         if (psel & ~pready & ~pwrite) begin
            case (paddr)
               `TWWD_CTRL_OFS:
                  prdata <= {8'h00, ^{cfg_window_r, key_b_r, per_r},
                             9'h000, key_b_r, cfg_window_r, 1'b0,
                             per_r, 8'h00};
               `TWWD_HWCTRL_OFS:
                  prdata <= {30'h0, wake_en_r, key_a_r};
               `TWWD_STATUS_OFS:
                  // running covers the long open window as well
                  prdata <= {27'h0,
                             (st_r == S_RUN) | (st_r == S_LONG),
                             ~reset_out_n, cmd_err_r, fail_r};
               `TWWD_MODE_OFS:
                  prdata <= {29'h0, mode_r};
               default:
                  pslverr <= 1'b1;
            endcase
         end else if (psel & ~pready) begin
            pslverr <= ~((paddr == `TWWD_CTRL_OFS) |
                         (paddr == `TWWD_HWCTRL_OFS) |
                         (paddr == `TWWD_STATUS_OFS) |
                         (paddr == `TWWD_MODE_OFS));
         end
      end
   end

   always @(posedge ref_clk) begin
      if (rst) begin
         mode_r          <= `TWWD_M_INIT;
         cfg_window_r    <= 1'b0;
         per_r           <= 3'h0;
         key_a_r         <= 1'b0;
         key_b_r         <= 1'b0;
         wake_en_r       <= 1'b1;
         fail_r          <= 2'h0;
         cmd_err_r       <= 1'b0;
         st_r            <= S_LOW;
         ms_r            <= 14'h0000;
         low_r           <= 32'h0000_0000;
         fail_wd_r       <= 1'b0;
         reset_out_n     <= 1'b0;
         can_receive_out <= 1'b1;
         wake_irq        <= 1'b0;
      end else begin
         wake_irq <= 1'b0;
         if (tick && ms_r != 14'h3FFF)
            ms_r <= ms_r + 14'h0001;
         // R11: bad parity sets command error, nothing else
         if (wr_ctl & ~par_ok)
            cmd_err_r <= 1'b1;
         else if (wr & (paddr == `TWWD_STATUS_OFS) &
                  pwdata[`TWWD_CMDERR_BIT])
            cmd_err_r <= 1'b0;
         if (trig & in_normal) begin
            cfg_window_r <= pwdata[`TWWD_CFG_BIT];
            per_r        <= pwdata[`TWWD_PER_HI:`TWWD_PER_LO];
            // R14: key b written without key a order keeps sequence
            key_b_r      <= pwdata[`TWWD_KEYB_BIT];
            // R16: new sequence start clears key a
            if (pwdata[`TWWD_KEYB_BIT] & key_a_r)
               key_a_r <= 1'b0;
         end
         if (wr_hw & in_normal) begin
            // R16: key a refused without key b
            // R13: second key only after the first
            if (pwdata[`TWWD_KEYA_BIT] & key_b_r)
               key_a_r <= 1'b1;
            // R14: key a before key b is a sequence error
            else if (pwdata[`TWWD_KEYA_BIT])
               key_b_r <= 1'b0;
            // R18: wake restart only in normal mode
            wake_en_r <= pwdata[`TWWD_WAKE_BIT];
         end
         if (wr_md) begin
            mode_r <= new_mode;
            if (new_mode == `TWWD_M_STOP && in_normal &&
                key_a_r && key_b_r) begin
               // R3: off in stop clears fail flags
               st_r   <= S_OFF;
               fail_r <= 2'h0;
            end else if (new_mode == `TWWD_M_SLEEP ||
                         new_mode == `TWWD_M_RESTART) begin
               st_r   <= S_OFF;
               fail_r <= 2'h0;
            end else if (new_mode == `TWWD_M_FAILSAFE) begin
               st_r <= S_OFF;
               if (!fail_wd_r)
                  fail_r <= 2'h0;
            end else if (in_normal == 1'b0 &&
                         (new_mode == `TWWD_M_NORMAL ||
                          new_mode == `TWWD_M_SWDEV)) begin
               // R15: back to normal restarts, keys cleared
               // R24: from init or restart use long window
               st_r    <= S_LONG;
               ms_r    <= 14'h0000;
               key_a_r <= 1'b0;
               key_b_r <= 1'b0;
               can_receive_out <= 1'b1;
            end
         end else begin
            case (st_r)
               S_LOW: begin
                  if (low_r >= LOW_CYC - 1) begin
                     // R24: reset release starts long window
                     reset_out_n <= 1'b1;
                     st_r        <= fail_wd_r & FAIL_TO_FAILSAFE ?
                                    S_OFF : S_LONG;
                     mode_r      <= fail_wd_r & FAIL_TO_FAILSAFE ?
                                    `TWWD_M_FAILSAFE : `TWWD_M_NORMAL;
                     ms_r        <= 14'h0000;
                     low_r       <= 32'h0000_0000;
                  end else
                     low_r <= low_r + 32'h0000_0001;
               end
               S_LONG: begin
                  // R25: trigger ends long window; expiry without one fails, except in development mode
                  if (trig & in_normal) begin
                     st_r   <= S_RUN;
                     ms_r   <= 14'h0000;
                     fail_r <= 2'h0;
                  end else if (long_end & mode_r == `TWWD_M_SWDEV)
                     ms_r <= 14'h0000;
                  else if (long_end) begin
                     fail_r    <= fail_r + {1'b0, ~&fail_r};
                     fail_wd_r <= 1'b1;
                     st_r      <= S_LOW;
                     reset_out_n <= 1'b0;
                     mode_r    <= `TWWD_M_RESTART;
                  end
               end
               S_RUN: begin
                  if (bad_trig | miss) begin
                     // R2: failure sets fail flags
                     fail_r <= fail_r + {1'b0, ~&fail_r};
                     // R1: development mode restarts long window
                     if (mode_r == `TWWD_M_SWDEV) begin
                        st_r <= S_LONG;
                        ms_r <= 14'h0000;
                     end else begin
                        // R5: reset low, restart or fail-safe
                        fail_wd_r   <= 1'b1;
                        st_r        <= S_LOW;
                        reset_out_n <= 1'b0;
                        mode_r      <= `TWWD_M_RESTART;
                     end
                  end else if (trig) begin
                     // R4: trigger restarts the period
                     // R6: new closed then open window
                     ms_r   <= 14'h0000;
                     // R3: good trigger clears fail flags
                     fail_r <= 2'h0;
                     fail_wd_r <= 1'b0;
                  end
               end
               S_OFF: begin
                  if (mode_r == `TWWD_M_STOP &&
                      (trig || (wake_rise && wake_en_r))) begin
                     // R15: stop-mode trigger re-enables
                     // R17: bus wake restarts watchdog
                     st_r    <= S_LONG;
                     ms_r    <= 14'h0000;
                     key_a_r <= 1'b0;
                     key_b_r <= 1'b0;
                     if (!trig) begin
                        // R19: irq and can receive low
                        wake_irq        <= 1'b1;
                        can_receive_out <= 1'b0;
                     end
                  end
               end
               default: st_r <= S_LOW;
            endcase
         end
      end
   end
endmodule // twwd_top

// file: include/twwd_defines.vh
`ifndef TWWD_DEFINES_VH
`define TWWD_DEFINES_VH
// apb register byte offsets
`define TWWD_CTRL_OFS      12'h000
`define TWWD_HWCTRL_OFS    12'h004
`define TWWD_STATUS_OFS    12'h008
`define TWWD_MODE_OFS      12'h00C
// control word fields (bit 22..8 xor equals checksum bit 23)
`define TWWD_CK_BIT        23
`define TWWD_PAR_HI        22
`define TWWD_PAR_LO        8
`define TWWD_KEYB_BIT      13
`define TWWD_CFG_BIT       12
`define TWWD_PER_HI        10
`define TWWD_PER_LO        8
`define TWWD_CTRL_RMASK    32'h0080_3700
// hardware control fields
`define TWWD_KEYA_BIT      0
`define TWWD_WAKE_BIT      1
// status fields
`define TWWD_FAIL_HI       1
`define TWWD_FAIL_LO       0
`define TWWD_CMDERR_BIT    2
`define TWWD_LOW_BIT       3
`define TWWD_RUN_BIT       4
// device modes
`define TWWD_M_NORMAL      3'h0
`define TWWD_M_STOP        3'h1
`define TWWD_M_SLEEP       3'h2
`define TWWD_M_RESTART     3'h3
`define TWWD_M_FAILSAFE    3'h4
`define TWWD_M_INIT        3'h5
`define TWWD_M_SWDEV       3'h6
// mode register field
`define TWWD_MODE_HI       2
`define TWWD_MODE_LO       0
// timing: 1 ms tick, closed window 60 %
`define TWWD_CLK_HZ        100000000
`define TWWD_TICK_US       1000
`define TWWD_CLOSED_PCT    60
`define TWWD_PCT_DIV       100
`define TWWD_LOW_US        1000
`endif

// file: verif/twwd_top_assertions.sv
`timescale 1ns/1ps
module twwd_chk (
   // clock and reset
   input wire        ref_clk,
   input wire        rst,
   // apb slave
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [11:0] paddr,
   input wire        pready,
   input wire        pslverr,
   // pins
   input wire        reset_out_n,
   input wire        can_receive_out,
   input wire        wake_irq
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   AST_READY_AFTER_SETUP: assert property (
      psel && !penable && !pready |=> pready) else $error("ready missing");
   AST_READY_ONE_CYCLE: assert property (
      pready |=> !pready) else $error("ready held");
   AST_READY_NEEDS_SEL: assert property (
      pready |-> $past(psel)) else $error("stray ready");
   AST_UNMAPPED_ERR: assert property (
      pready && paddr > 12'h00C |-> pslverr) else $error("no slave error");
   AST_MAPPED_OK: assert property (
      pready && paddr <= 12'h00C && paddr[1:0] == 2'b00 |-> !pslverr)
      else $error("false slave error");
   AST_LOW_AFTER_RESET: assert property (
      $fell(rst) |-> !reset_out_n [*8]) else $error("reset out released");
   AST_IRQ_PULSE: assert property (
      wake_irq |=> !wake_irq) else $error("irq too long");
   AST_IRQ_CAN_LOW: assert property (
      wake_irq |-> ##[0:2] !can_receive_out) else $error("can stays high");
   AST_CAN_BACK_ON_MODE: assert property (
      $rose(can_receive_out) |-> $past(psel && penable && pwrite) ||
      $past(psel && penable && pwrite, 2)) else $error("can rose alone");
endmodule // twwd_chk

bind twwd_top twwd_chk twwd_chk_inst (
   .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
   .reset_out_n(reset_out_n), .can_receive_out(can_receive_out),
   .wake_irq(wake_irq));

// file: verif/twwd_top_tb_top.sv
`timescale 1ns/1ps
`include "twwd_defines.vh"
module twwd_top_tb_top;
   logic        ref_clk = 1'b0;
   logic        rst = 1'b1;
   logic        bus_wake = 1'b0;
   wire         psel, penable, pwrite, pready, pslverr;
   wire         reset_out_n, can_receive_out, wake_irq;
   wire  [11:0] paddr;
   wire  [31:0] pwdata, prdata;
   logic [31:0] q;
   logic        e;
   int          error_cnt = 0;
   int          check_count = 0;
   int          i;
   always #5 ref_clk = ~ref_clk;
   twwd_uc_model twwd_uc_model_inst (.ref_clk(ref_clk), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr));
   // short tick keeps periods at ten cycles a millisecond
   twwd_top #(.LONG_MS(20), .TICK_CYC(10), .FAIL_TO_FAILSAFE(0))
   twwd_top_inst (.ref_clk(ref_clk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .bus_wake(bus_wake), .reset_out_n(reset_out_n),
      .can_receive_out(can_receive_out), .wake_irq(wake_irq));
   task chk(input logic [31:0] g, input logic [31:0] x);
      check_count++;
      if (g !== x) begin
         error_cnt++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask
   task end_of_test;
      $display("mismatches=%0d checks=%0d", error_cnt, check_count);
      if (error_cnt == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task rd(input logic [11:0] a);
      twwd_uc_model_inst.xfer(1'b0, a, 32'h0000_0000, q, e);
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      twwd_uc_model_inst.xfer(1'b1, a, d, q, e);
   endtask
   task ctl(input logic [31:0] d, input logic flip);
      twwd_uc_model_inst.wr_ctrl(d, flip);
   endtask
   // whole run is about a thousand cycles; this is far past it
   initial begin
      repeat (20000) @(posedge ref_clk);
      error_cnt++;
      end_of_test();
   end
   initial begin
      repeat (5) @(posedge ref_clk);
      rst <= 1'b0;
      i = 0;
      while (reset_out_n !== 1'b1 && i < 2000) begin
         @(posedge ref_clk);
         i++;
      end
      chk({31'h0, reset_out_n}, 32'h0000_0001);
      rd(`TWWD_HWCTRL_OFS);
      chk(q, 32'h0000_0002);
      rd(`TWWD_STATUS_OFS);
      chk(q, 32'h0000_0010);
      rd(12'h010);
      chk({31'h0, e}, 32'h0000_0001);
      // reserved bit 14 set: accepted only if it counts in the parity
      ctl(32'h0000_4300, 1'b0);
      rd(`TWWD_CTRL_OFS);
      chk(q, 32'h0000_0300);
      ctl(32'h0000_0100, 1'b1);
      rd(`TWWD_CTRL_OFS);
      chk(q, 32'h0000_0300);
      rd(`TWWD_STATUS_OFS);
      chk(q, 32'h0000_0014);
      wr(`TWWD_STATUS_OFS, 32'h0000_0004);
      ctl(32'h0000_0000, 1'b0);
      // time-out mode served at 0.8 of the 10 ms period
      repeat (3) begin
         repeat (80) @(posedge ref_clk);
         ctl(32'h0000_0000, 1'b0);
      end
      rd(`TWWD_STATUS_OFS);
      chk(q, 32'h0000_0010);
      ctl(32'h0000_0300, 1'b0);
      wr(`TWWD_HWCTRL_OFS, 32'h0000_0003);
      rd(`TWWD_HWCTRL_OFS);
      chk(q, 32'h0000_0002);
      ctl(32'h0000_2300, 1'b0);
      wr(`TWWD_HWCTRL_OFS, 32'h0000_0003);
      rd(`TWWD_HWCTRL_OFS);
      chk(q, 32'h0000_0003);
      wr(`TWWD_MODE_OFS, 32'h0000_0001);
      rd(`TWWD_STATUS_OFS);
      chk(q, 32'h0000_0000);
      bus_wake <= 1'b1;
      i = 0;
      while (wake_irq !== 1'b1 && i < 50) begin
         @(posedge ref_clk);
         i++;
      end
      chk({31'h0, wake_irq}, 32'h0000_0001);
      @(posedge ref_clk);
      chk({31'h0, can_receive_out}, 32'h0000_0000);
      bus_wake <= 1'b0;
      rd(`TWWD_STATUS_OFS);
      chk(q, 32'h0000_0010);
      // back to normal before any new disable
      wr(`TWWD_MODE_OFS, 32'h0000_0000);
      rd(`TWWD_CTRL_OFS);
      chk(q & 32'h0000_2000, 32'h0000_0000);
      rd(`TWWD_HWCTRL_OFS);
      chk(q, 32'h0000_0002);
      chk({31'h0, can_receive_out}, 32'h0000_0001);
      // window trigger at 0.8 of the period, then one inside closed part
      ctl(32'h0000_1000, 1'b0);
      repeat (80) @(posedge ref_clk);
      ctl(32'h0000_1000, 1'b0);
      rd(`TWWD_STATUS_OFS);
      chk(q, 32'h0000_0010);
      repeat (30) @(posedge ref_clk);
      ctl(32'h0000_1000, 1'b0);
      i = 0;
      while (reset_out_n !== 1'b0 && i < 20) begin
         @(posedge ref_clk);
         i++;
      end
      chk({31'h0, reset_out_n}, 32'h0000_0000);
      rd(`TWWD_STATUS_OFS);
      chk({30'h0, q[1:0]}, 32'h0000_0001);
      i = 0;
      while (reset_out_n !== 1'b1 && i < 2000) begin
         @(posedge ref_clk);
         i++;
      end
      chk({31'h0, reset_out_n}, 32'h0000_0001);
      // development mode: misses keep the mode and never pull reset
      wr(`TWWD_MODE_OFS, 32'h0000_0006);
      repeat (250) @(posedge ref_clk);
      rd(`TWWD_MODE_OFS);
      chk(q, 32'h0000_0006);
      ctl(32'h0000_0000, 1'b0);
      repeat (150) @(posedge ref_clk);
      chk({31'h0, reset_out_n}, 32'h0000_0001);
      rd(`TWWD_STATUS_OFS);
      chk(q, 32'h0000_0011);
      rd(`TWWD_MODE_OFS);
      chk(q, 32'h0000_0006);
      end_of_test();
   end
endmodule // twwd_top_tb_top

// file: verif/twwd_uc_model.sv
`timescale 1ns/1ps
`include "twwd_defines.vh"
module twwd_uc_model (
   // clock
   input  wire        ref_clk,
   // apb master
   output reg         psel,
   output reg         penable,
   output reg         pwrite,
   output reg  [11:0] paddr,
   output reg  [31:0] pwdata,
   input  wire [31:0] prdata,
   input  wire        pready,
   input  wire        pslverr
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
   end
   // request held until pready is seen high
   task automatic xfer(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic e);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // checksum over 22..8; flip makes it wrong on purpose
   task automatic wr_ctrl(input logic [31:0] d, input logic flip);
      logic [31:0] q;
      logic        e;
      d[`TWWD_CK_BIT] = ^d[22:8] ^ flip;
      xfer(1'b1, `TWWD_CTRL_OFS, d, q, e);
   endtask
endmodule // twwd_uc_model
